/* File: include/rdf_consts.vh */
`ifndef RDF_CONSTS_VH
`define RDF_CONSTS_VH
// Register byte offsets on APB
`define RDF_REG_CTRL 8'h00
`define RDF_REG_IBASE 8'h04
`define RDF_REG_STAT 8'h08
`define RDF_REG_CDESC 8'h0C
`define RDF_REG_CMD 8'h10
// Initialization block layout, byte offsets
`define RDF_IB_ENTRY_BYTES 24'h000008
`define RDF_IB_TX_HI 24'h000000
`define RDF_IB_TX_LO 24'h000002
`define RDF_IB_RX_HI 24'h000004
`define RDF_IB_RX_LO 24'h000006
// Descriptor word offsets
`define RDF_D_CTL 24'h000000
`define RDF_D_BUF_HI 24'h000002
`define RDF_D_BUF_LO 24'h000004
`define RDF_D_NXT_HI 24'h000006
`define RDF_D_NXT_LO 24'h000008
`define RDF_D_STATUS 24'h00000A
// Descriptor word 0 fields
`define RDF_IBF_BIT 13
`define RDF_QEND_BIT 12
// Status word fields
`define RDF_ST_FRAME 15
`define RDF_ST_ABORT 14
`define RDF_ST_OVF 13
`define RDF_ST_CHK 12
// Frame outcome codes from the receiver
`define RDF_END_NONE 3'h0
`define RDF_END_GOOD 3'h1
`define RDF_END_CHK 3'h2
`define RDF_END_ABORT 3'h3
`define RDF_END_OVF 3'h4
`define RDF_END_ODD 3'h5
`endif

/* File: design/rdf_rx_dma.v */
`timescale 1ns/10ps
`default_nettype none
`include "rdf_consts.vh"
module rdf_rx_dma #(
  parameter CH_BITS = 6
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Receive byte stream from the frame receiver
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire [2:0] rx_end,
  output wire rx_ready,
  // Shared memory master, 16-bit words
  output reg mem_req,
  output reg mem_we,
  output reg [23:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire mem_ack,
  input wire [15:0] mem_rdata,
  // Frame event flag towards the interrupt register
  output reg frame_irq
);

  // One-hot walk states. IDLE waits for a start command; IBHI and IBLO read the
  // receive pair of the channel's entry in the init block; DESC reads the five
  // software words of a descriptor; RECV takes bytes from the stream; DATA holds
  // one data word until memory takes it; STAT writes the status word; NEXT loads
  // the next descriptor address from the chain; HALT parks after a queue end.
  // Only one memory request is ever outstanding, so the stream stalls while a
  // word is in flight. That keeps the block free of a data buffer, at the cost of
  // stream throughput when memory is slow or shared with the host.
  // Limitation: the walk never checks a pointer against the memory size, so a
  // broken chain is followed wherever it points until a queue end on a descriptor of nonzero size stops it.
  // A start while the walk is busy is refused; software must wait for the halt
  // event before it resumes a channel.
  // The stream's end codes carry no data byte; an odd byte still held in the low
  // half is flushed before the status word, so status never overtakes data.
  // The status word is only written when a buffer is done, which is why a zero
  // count left by software reads as reception still in progress.
  localparam S_IDLE = 9'h001;
  localparam S_IBHI = 9'h002;
  localparam S_IBLO = 9'h004;
  localparam S_DESC = 9'h008;
  localparam S_RECV = 9'h010;
  localparam S_DATA = 9'h020;
  localparam S_STAT = 9'h040;
  localparam S_HALT = 9'h080;
  localparam S_NEXT = 9'h100;

  // Walk registers: desc_q is the descriptor in use, buf_q its buffer, nxt_q
  // the link to follow; wcnt_q counts words stored and nbr_q bytes taken.
  // half_q says a low byte waits in lo_q for its partner.
  // end_q keeps the outcome of the frame until its status word is written.
  reg [8:0] st_q;
  reg [23:0] ibase_q, desc_q, buf_q, nxt_q;
  reg [CH_BITS-1:0] chan_q;
  reg [2:0] widx_q;
  reg [11:0] size_q, wcnt_q;
  reg [12:0] nbr_q;
  reg ibf_q, qend_q, enable_q, half_q;
  reg [7:0] lo_q;
  reg [15:0] stat_q;
  reg [2:0] end_q;
  reg start_q;
  wire apb_wr = psel & penable & pwrite;

  // Handshake and address decodes shared by several states
  wire rx_take = rx_valid & rx_ready;
  wire [23:0] data_addr = buf_q + {12'h000, wcnt_q[10:0], 1'b0};
  wire [23:0] stat_addr = desc_q + `RDF_D_STATUS;
  wire [11:0] wcnt_inc = wcnt_q + 12'h001;
  // Last word of a buffer: frame ended or the buffer is now full
  wire buf_last = (end_q != `RDF_END_NONE) || (wcnt_inc == size_q);

  // Word address helper: bit 0 always dropped, memory is word wide
  function [23:0] waddr;
    input [23:0] a;
    waddr = {a[23:1], 1'b0};
  endfunction

  // Outcome bits for the status word
  function [3:0] outcome;
    input [2:0] e;
    case (e)
      `RDF_END_GOOD: outcome = 4'h8;
      `RDF_END_CHK: outcome = 4'h9;
      `RDF_END_ABORT: outcome = 4'h4;
      `RDF_END_OVF: outcome = 4'h6;
      `RDF_END_ODD: outcome = 4'h5;
      default: outcome = 4'h0;
    endcase
  endfunction

  // Entry of channel n starts n*8 bytes above the base; rx pair follows tx pair.
  // Built by part-select so a wider channel field never spills past 24 bits.
  function [23:0] entry_addr;
    input [23:0] base;
    input [CH_BITS-1:0] ch;
    reg [23:0] off;
    begin
      off = 24'h000000;
      off[CH_BITS+2:3] = ch;
      entry_addr = waddr(base + off + `RDF_IB_RX_HI);
    end
  endfunction

  // Byte count for the status word; a count of 4096 cannot fit the 12-bit
  // field, so it saturates instead of wrapping to zero, which software
  // would read as reception still in progress
  function [11:0] count_field;
    input [12:0] n;
    begin
      if (n[12]) count_field = 12'hFFF;
      else count_field = n[11:0];
    end
  endfunction

  // APB answers in the access cycle, no wait states
  // Errors are never flagged: unmapped offsets read zero and ignore writes
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign rx_ready = st_q[4];

  // Read mux
  // Purely combinational, so read data stands for as long as the address does
  always @* begin
    case (paddr)
      `RDF_REG_CTRL: prdata = {31'h0, enable_q};
      `RDF_REG_IBASE: prdata = {8'h00, ibase_q};
      `RDF_REG_STAT: prdata = {16'h0, stat_q};
      `RDF_REG_CDESC: prdata = {8'h00, desc_q};
      default: prdata = 32'h0;
    endcase
  end

  // Software registers and start command
  // A start written while disabled stays pending and runs once enabled
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
      ibase_q <= 24'h000000;
      start_q <= 1'b0;
      chan_q <= {CH_BITS{1'b0}};
    end else begin
      if (apb_wr && paddr == `RDF_REG_CTRL) enable_q <= pwdata[0];
      if (apb_wr && paddr == `RDF_REG_IBASE) ibase_q <= waddr(pwdata[23:0]);
      // Start only accepted while idle or halted; restart re-reads the block
      if (apb_wr && paddr == `RDF_REG_CMD && (st_q[0] || st_q[7])) begin
        start_q <= 1'b1;
        chan_q <= pwdata[CH_BITS-1:0];
      end else if (!st_q[0] && !st_q[7]) begin
        start_q <= 1'b0;
      end
    end
  end

  // Main walk over the init block, descriptors and buffers
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 16'h0000;
      desc_q <= 24'h000000;
      buf_q <= 24'h000000;
      nxt_q <= 24'h000000;
      widx_q <= 3'h0;
      size_q <= 12'h000;
      wcnt_q <= 12'h000;
      nbr_q <= 13'h0000;
      ibf_q <= 1'b0;
      qend_q <= 1'b0;
      half_q <= 1'b0;
      lo_q <= 8'h00;
      stat_q <= 16'h0000;
      end_q <= 3'h0;
      frame_irq <= 1'b0;
    end else begin
      frame_irq <= 1'b0;
      case (st_q)
        // Idle, or halted after a queue end: only a new start leaves
        S_IDLE, S_HALT: begin
          if (start_q && enable_q) begin
            // Read the rx pair of the channel's entry at once
            mem_addr <= entry_addr(ibase_q, chan_q);
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            st_q <= S_IBHI;
          end
        end
        // High byte of the first descriptor address
        S_IBHI: if (mem_ack) begin
          desc_q[23:16] <= mem_rdata[7:0];
          mem_addr <= mem_addr + `RDF_D_BUF_HI;
          st_q <= S_IBLO;
        end
        // Low word completes the pointer; bit 0 is dropped even if software
        // left it set, so the first descriptor read is always word aligned
        S_IBLO: if (mem_ack) begin
          desc_q <= waddr({desc_q[23:16], mem_rdata});
          mem_addr <= waddr({desc_q[23:16], mem_rdata});
          widx_q <= 3'h0;
          st_q <= S_DESC;
        end
        // Read the five software words; never written here
        S_DESC: if (mem_ack) begin
          widx_q <= widx_q + 3'h1;
          mem_addr <= mem_addr + `RDF_D_BUF_HI;
          case (widx_q)
            3'h0: begin
              ibf_q <= mem_rdata[`RDF_IBF_BIT];
              qend_q <= mem_rdata[`RDF_QEND_BIT];
              size_q <= mem_rdata[11:0];
            end
            3'h1: buf_q[23:16] <= mem_rdata[7:0];
            3'h2: buf_q[15:0] <= {mem_rdata[15:1], 1'b0};
            3'h3: nxt_q[23:16] <= mem_rdata[7:0];
            default: begin
              nxt_q[15:0] <= {mem_rdata[15:1], 1'b0};
              mem_req <= 1'b0;
              wcnt_q <= 12'h000;
              nbr_q <= 13'h0000;
              half_q <= 1'b0;
              // Size zero: skip straight to the next descriptor
              st_q <= (size_q == 12'h000) ? S_NEXT : S_RECV;
            end
          endcase
        end
        // The stream is taken only here; a byte that completes a word stalls
        // the stream until the word lands, which is the only buffering kept
        S_RECV: begin
          if (rx_take) begin
            if (rx_end != `RDF_END_NONE) begin
              end_q <= rx_end;
              if (half_q) begin
                // Flush last odd byte before status
                mem_wdata <= {8'h00, lo_q};
                mem_addr <= data_addr;
                mem_we <= 1'b1;
                mem_req <= 1'b1;
                st_q <= S_DATA;
              end else begin
                mem_wdata <= {outcome(rx_end), count_field(nbr_q)};
                mem_addr <= stat_addr;
                mem_we <= 1'b1;
                mem_req <= 1'b1;
                st_q <= S_STAT;
              end
            end else begin
              nbr_q <= nbr_q + 13'h0001;
              half_q <= ~half_q;
              if (!half_q) begin
                lo_q <= rx_byte;
              end else begin
                mem_wdata <= {rx_byte, lo_q};
                mem_addr <= data_addr;
                mem_we <= 1'b1;
                mem_req <= 1'b1;
                end_q <= `RDF_END_NONE;
                st_q <= S_DATA;
              end
            end
          end
        end
        // Data word in flight; the status write follows the last word of a buffer
        S_DATA: if (mem_ack) begin
          wcnt_q <= wcnt_inc;
          half_q <= 1'b0;
          if (buf_last) begin
            // Data word landed; now the status follows it
            mem_wdata <= {outcome(end_q), count_field(nbr_q)};
            mem_addr <= stat_addr;
            st_q <= S_STAT;
          end else begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st_q <= S_RECV;
          end
        end
        // Status landed; a copy stays readable by software. The event is a
        // one-cycle pulse, so the interrupt register must latch it.
        S_STAT: if (mem_ack) begin
          stat_q <= mem_wdata;
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          // Buffer done: raise frame event when asked or at queue end
          frame_irq <= ibf_q | qend_q;
          st_q <= qend_q ? S_HALT : S_NEXT;
        end
        // Follow the chain with no length limit
        // The link was already made even when its word was read
        S_NEXT: begin
          desc_q <= nxt_q;
          mem_addr <= nxt_q;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          widx_q <= 3'h0;
          st_q <= S_DESC;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: dv/rdf_rx_dma_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdf_consts.vh"
module rdf_rx_dma_assertions (
  // Clock, reset and APB
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Stream, memory and event
  input wire logic rx_valid,
  input wire logic [2:0] rx_end,
  input wire logic rx_ready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic frame_irq
);
  logic [23:0] base_q;
  logic [23:0] ent_q;
  logic [2:0] end_q;
  logic [3:0] since_wr_q;
  logic en_q;
  wire cmd_wr = psel && penable && pwrite && paddr == `RDF_REG_CMD;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Expected outcome nibble per end code
  function automatic logic [3:0] nib(input logic [2:0] e);
    case (e)
      3'h1: nib = 4'h8;
      3'h2: nib = 4'h9;
      3'h3: nib = 4'h4;
      3'h4: nib = 4'h6;
      default: nib = 4'h5;
    endcase
  endfunction
  // Shadow of the entry address and write age; saturates so old writes never look fresh
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= 24'h0;
      ent_q <= 24'h0;
      end_q <= 3'h0;
      since_wr_q <= 4'hF;
      en_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == `RDF_REG_CTRL) en_q <= pwdata[0];
      if (psel && penable && pwrite && paddr == `RDF_REG_IBASE) base_q <= pwdata[23:0];
      if (cmd_wr) ent_q <= base_q + {15'h0, pwdata[5:0], 3'h0} + `RDF_IB_RX_HI;
      if (rx_valid && rx_ready && rx_end != 3'h0) end_q <= rx_end;
      if (mem_req && mem_we && mem_ack) since_wr_q <= 4'h0;
      else if (since_wr_q != 4'hF) since_wr_q <= since_wr_q + 4'h1;
    end
  end
  sequence s_start;
    cmd_wr && en_q && !rx_ready && !mem_req;
  endsequence
  sequence s_hi_taken;
    mem_req && mem_ack && !mem_we && mem_addr == ent_q;
  endsequence
  property p_start_fetch;
    s_start |-> ##[1:4] (mem_req && !mem_we && mem_addr == ent_q);
  endproperty
  a_start_fetch: assert property (p_start_fetch) else $error("start did not fetch entry");
  property p_entry_lo;
    s_hi_taken |=> ##[0:4] (mem_req && !mem_we && mem_addr == ent_q + 24'h2);
  endproperty
  a_entry_lo: assert property (p_entry_lo) else $error("entry low word not read");
  property p_desc_read;
    mem_req && mem_ack && !mem_we && mem_addr == ent_q + 24'h2 |=> ##[0:4] (mem_req && !mem_we);
  endproperty
  a_desc_read: assert property (p_desc_read) else $error("descriptor not read");
  property p_addr_even;
    mem_req |-> !mem_addr[0];
  endproperty
  a_addr_even: assert property (p_addr_even) else $error("odd memory address");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed");
  property p_irq_pulse;
    frame_irq |=> !frame_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("event flag too long");
  property p_irq_after_wr;
    frame_irq |-> since_wr_q < 4'h4;
  endproperty
  a_irq_after_wr: assert property (p_irq_after_wr) else $error("event without status write");
  property p_end_status;
    rx_valid && rx_ready && rx_end != 3'h0 |=> ##[0:40] (mem_req && mem_we && mem_ack && mem_wdata[15:12] == nib(end_q));
  endproperty
  a_end_status: assert property (p_end_status) else $error("wrong frame outcome");
endmodule
bind rdf_rx_dma rdf_rx_dma_assertions rdf_rx_dma_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_valid(rx_valid),
  .rx_end(rx_end), .rx_ready(rx_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .frame_irq(frame_irq));
`default_nettype wire

/* File: dv/rdf_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rdf_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Memory slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:511];
  logic [1:0] wait_q;
  logic [1:0] slow = 2'h0;
  // Word store; read data is only valid in the acknowledge cycle, then toggles
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 16'h0;
    end else if (mem_req && !mem_ack && wait_q == slow) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      mem_rdata <= mem[mem_addr[9:1]];
      if (mem_we) mem[mem_addr[9:1]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_rdf_rx_dma.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_rdf_rx_dma;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_valid = 1'b0;
  logic [7:0] paddr = 8'h00, rx_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] rx_end = 3'h0;
  logic pready, pslverr, rx_ready, mem_req, mem_we, mem_ack, frame_irq;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [15:0] exp_st [1:5] = '{16'h8000, 16'h9000, 16'h4000, 16'h6000, 16'h5000};
  int bad_count = 0;
  int checked = 0;
  rdf_rx_dma rdf_rx_dma_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end), .rx_ready(rx_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .frame_irq(frame_irq));
  rdf_mem_model rdf_mem_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; the leading edge keeps back-to-back calls from reassigning psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Ready is judged at the falling edge so the taking edge is known without a race
  task automatic send(input logic [7:0] b, input logic [2:0] e);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    rx_end <= e;
    do @(negedge ref_clk); while (rx_ready !== 1'b1);
    @(posedge ref_clk);
    rx_valid <= 1'b0;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (frame_irq !== 1'b1 && n < 300);
    check({31'h0, frame_irq}, 32'h1);
  endtask
  task automatic put(input logic [23:0] a, input logic [15:0] v);
    rdf_mem_model_inst.mem[a[9:1]] = v;
  endtask
  initial begin
    #400000;
    bad_count++;
    results();
  end
  initial begin
    rdf_mem_model_inst.slow = 2'h2;
    put(24'h4C, 16'h0000);
    put(24'h4E, 16'h0080);
    put(24'h80, 16'h0000);
    put(24'h86, 16'h0000);
    put(24'h88, 16'h0090);
    put(24'h8A, 16'h5A5A);
    put(24'h90, 16'h2002);
    put(24'h92, 16'h0000);
    put(24'h94, 16'h00C0);
    put(24'h96, 16'h0000);
    put(24'h98, 16'h00A0);
    put(24'hA0, 16'h1004);
    put(24'hA2, 16'h0000);
    put(24'hA4, 16'h00D0);
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h10, 32'h1);
    // Four bytes fill the first real buffer, a fifth ends the frame in the next one
    send(8'h11, 3'h0);
    send(8'h22, 3'h0);
    send(8'h33, 3'h0);
    send(8'h44, 3'h0);
    wait_irq();
    send(8'h55, 3'h0);
    send(8'h00, 3'h1);
    wait_irq();
    repeat (4) @(posedge ref_clk);
    check({31'h0, rx_ready}, 32'h0);
    check(rdf_mem_model_inst.mem[12'h8A >> 1], 32'h5A5A);
    check(rdf_mem_model_inst.mem[12'h9A >> 1], 32'h0004);
    check(rdf_mem_model_inst.mem[12'hC0 >> 1], 32'h2211);
    check(rdf_mem_model_inst.mem[12'hC2 >> 1], 32'h4433);
    check(rdf_mem_model_inst.mem[12'hD0 >> 1] & 16'h00FF, 32'h55);
    check(rdf_mem_model_inst.mem[12'hAA >> 1], 32'h8001);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h8001);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'hA0);
    check({31'h0, pslverr}, 32'h0);
    // Every end code, entry pointer with bit 0 set, varying memory latency
    for (int k = 1; k <= 5; k++) begin
      rdf_mem_model_inst.slow = k[1:0];
      put(24'h4E, 16'h0101);
      put(24'h100, 16'h1004);
      put(24'h102, 16'h0000);
      put(24'h104, 16'h0140);
      put(24'h10A, 16'h0000);
      apb(1'b1, 8'h10, 32'h1);
      send(8'h60, 3'h0);
      send(8'h00, k[2:0]);
      wait_irq();
      check(rdf_mem_model_inst.mem[12'h10A >> 1] & 16'hF000, exp_st[k]);
    end
    // Disabled: a start command must not reach the memory
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    repeat (20) @(posedge ref_clk);
    check({31'h0, mem_req}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire
